// ==== rtl/ats_trigger_select.sv ====
// Trigger source selector with AHB-Lite register bank
`timescale 1ns/1ps

module ats_trigger_select
#(
    parameter bit MOTOR_CONTROL = 1'b1 // PWM-derived sources present
)
(
    input wire logic I_MCLK, // Peripheral clock, 125 MHz
    input wire logic I_SYS_RST, // Async reset, active high
    input wire ats_pkg::ats_ahb_req_type I_AHB, // AHB address phase
    input wire logic [31:0] I_HWDATA, // AHB write data
    output logic [31:0] O_HRDATA, // AHB read data
    output logic O_HREADYOUT, // Slave ready, never stalls
    output logic O_HRESP, // Always OKAY
    input wire ats_pkg::ats_src_type I_TRIG_SRC, // Trigger events
    output logic [ats_pkg::ATS_NUM_CH-1:0] O_CONV_REQ, // One-cycle req
    output logic [ats_pkg::ATS_NUM_CH-1:0] O_TRIG_LEVEL // Selected level
);
    import ats_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (ATS_BANK2_FIRST + ATS_BANK2_FIELDS != ATS_BANK3_FIRST ||
            ATS_BANK4_FIRST + ATS_BANK_FIELDS != ATS_NUM_CH)
        begin : g_bad_layout
            $error("Channel layout does not match the bank map");
        end
    endgenerate

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [ATS_SEL_W-1:0] sel_ff [ATS_NUM_CH];
    logic [ATS_SEL_W-1:0] nxt_sel [ATS_NUM_CH];
    logic act_ff;
    logic wr_ff;
    logic [ATS_ADDR_W-1:0] addr_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [ATS_NUM_CH-1:0] lvl_ff;
    logic [ATS_NUM_CH-1:0] req_ff;
    logic [ATS_NUM_CH-1:0] sel_event;
    logic [ATS_NUM_CODES-1:0] src_vec;
    logic addr_take;
    logic data_wr;

    // ------------------------------------------------------------
    // Source vector, indexed by selection code
    // ------------------------------------------------------------
    // Non motor-control parts have no PWM unit, so those codes stay
    // silent rather than forwarding a floating input.
    logic mc;
    assign mc = MOTOR_CONTROL;

    always_comb
    begin
        src_vec = '0;
        src_vec[0] = 1'b0;
        src_vec[1] = I_TRIG_SRC.sw_edge;
        src_vec[2] = I_TRIG_SRC.sw_level;
        src_vec[3] = I_TRIG_SRC.scan;
        src_vec[4] = I_TRIG_SRC.ext_int0;
        src_vec[5] = I_TRIG_SRC.gp_timer1;
        src_vec[6] = I_TRIG_SRC.gp_timer3;
        src_vec[7] = I_TRIG_SRC.gp_timer5;
        src_vec[8] = I_TRIG_SRC.pri_special & mc;
        src_vec[9] = I_TRIG_SRC.sec_special & mc;
        src_vec[15:10] = I_TRIG_SRC.pwm_trig[5:0] & {6{mc}};
        src_vec[19:16] = I_TRIG_SRC.oc_rise;
        src_vec[20] = I_TRIG_SRC.charge_time_measurement_unit_trip;
        src_vec[23:21] = I_TRIG_SRC.pwm_trig[8:6] & {3{mc}};
        src_vec[27:24] = I_TRIG_SRC.pwm_climit & {4{mc}};
        src_vec[30:28] = I_TRIG_SRC.pwm_trig[11:9] & {3{mc}};
        src_vec[31] = 1'b0;
    end

    // ------------------------------------------------------------
    // AHB-Lite address phase
    // ------------------------------------------------------------
    assign addr_take = I_AHB.hsel && I_AHB.hready &&
        (I_AHB.htrans == ATS_HTRANS_NONSEQ || I_AHB.htrans == 2'h3);
    assign data_wr = act_ff && wr_ff;

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
        end
        else if (I_AHB.hready)
        begin
            act_ff <= addr_take;
            wr_ff <= addr_take && I_AHB.hwrite;
            addr_ff <= I_AHB.haddr;
        end
    end

    // ------------------------------------------------------------
    // Field writes
    // ------------------------------------------------------------
    // Only the five field bits of each byte are stored; the three bits
    // above them have no flops and so ignore writes.
    always_comb
    begin
        for (int c = 0; c < ATS_NUM_CH; c++)
        begin
            nxt_sel[c] = sel_ff[c];
        end
        if (data_wr)
        begin
            case (addr_ff)
                ATS_OFS_BANK2:
                begin
                    for (int f = 0; f < ATS_BANK2_FIELDS; f++)
                    begin
                        nxt_sel[ATS_BANK2_FIRST + f] =
                            I_HWDATA[f*ATS_FIELD_STRIDE +: ATS_SEL_W];
                    end
                end
                ATS_OFS_BANK3:
                begin
                    for (int f = 0; f < ATS_BANK_FIELDS; f++)
                    begin
                        nxt_sel[ATS_BANK3_FIRST + f] =
                            I_HWDATA[f*ATS_FIELD_STRIDE +: ATS_SEL_W];
                    end
                end
                ATS_OFS_BANK4:
                begin
                    for (int f = 0; f < ATS_BANK_FIELDS; f++)
                    begin
                        nxt_sel[ATS_BANK4_FIRST + f] =
                            I_HWDATA[f*ATS_FIELD_STRIDE +: ATS_SEL_W];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            for (int c = 0; c < ATS_NUM_CH; c++)
            begin
                sel_ff[c] <= ATS_SEL_RESET;
            end
        end
        else
        begin
            for (int c = 0; c < ATS_NUM_CH; c++)
            begin
                sel_ff[c] <= nxt_sel[c];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data is built from the next field values so that a read
    // right behind a write to the same bank returns the new value.
    always_comb
    begin
        nxt_rdata = ATS_BANK_RESET;
        case (I_AHB.haddr)
            ATS_OFS_BANK2:
            begin
                for (int f = 0; f < ATS_BANK2_FIELDS; f++)
                begin
                    nxt_rdata[f*ATS_FIELD_STRIDE +: ATS_SEL_W] =
                        nxt_sel[ATS_BANK2_FIRST + f];
                end
            end
            ATS_OFS_BANK3:
            begin
                for (int f = 0; f < ATS_BANK_FIELDS; f++)
                begin
                    nxt_rdata[f*ATS_FIELD_STRIDE +: ATS_SEL_W] =
                        nxt_sel[ATS_BANK3_FIRST + f];
                end
            end
            ATS_OFS_BANK4:
            begin
                for (int f = 0; f < ATS_BANK_FIELDS; f++)
                begin
                    nxt_rdata[f*ATS_FIELD_STRIDE +: ATS_SEL_W] =
                        nxt_sel[ATS_BANK4_FIRST + f];
                end
            end
            ATS_OFS_STATUS:
            begin
                nxt_rdata[ATS_NUM_CH-1:0] = lvl_ff;
            end
            default:
            begin
                nxt_rdata = ATS_BANK_RESET;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            rdata_ff <= '0;
        end
        else if (addr_take && !I_AHB.hwrite)
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign O_HRDATA = rdata_ff;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = ATS_HRESP_OKAY;

    // ------------------------------------------------------------
    // Per-channel trigger forwarding
    // ------------------------------------------------------------
    // A request is the rising edge of the selected event. A source that
    // is already high when software selects it yields one request if the previous selection was low.
    genvar g;
    generate
        for (g = 0; g < ATS_NUM_CH; g++)
        begin : g_ch
            assign sel_event[g] = src_vec[sel_ff[g]];

            always_ff @(posedge I_MCLK or posedge I_SYS_RST)
            begin
                if (I_SYS_RST)
                begin
                    lvl_ff[g] <= 1'b0;
                    req_ff[g] <= 1'b0;
                end
                else
                begin
                    lvl_ff[g] <= sel_event[g];
                    req_ff[g] <= sel_event[g] & ~lvl_ff[g];
                end
            end
        end
    endgenerate

    assign O_CONV_REQ = req_ff;
    assign O_TRIG_LEVEL = lvl_ff;

endmodule

// ==== rtl/ats_pkg.sv ====
// Package: constants, register map and types of the ADC trigger selector
// Notes on behaviour
// - Code 0 no trigger, 1 software edge
// - Code 2 software level; sensitivity set elsewhere
// - Code 3 routes common scan trigger
// - Codes 4-7: external pin, timers 1/3/5
// - Codes 8, 9: primary, secondary special event
// - Codes 10-15: PWM generators 1-6 triggers
// - Codes 16-19: output compare 1-4 rising
// - Code 20 charge trip; 21-23 PWM 7-9
// - Codes 24-27: PWM 1-4 current limit
// - Codes 28-30 PWM 10-12; 31 reserved
// - PWM sources only on motor-control variants
// - Bits above each field read zero
// - Every field uses the same encoding
// - Bank layout: cores 4,5, input 6; 8-15
// - All fields read/write, reset to zero
package ats_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ATS_OFS_BANK2 = 8'h00;
    localparam logic [7:0] ATS_OFS_BANK3 = 8'h04;
    localparam logic [7:0] ATS_OFS_BANK4 = 8'h08;
    localparam logic [7:0] ATS_OFS_STATUS = 8'h0C;
    localparam int ATS_ADDR_W = 8;
    localparam logic [31:0] ATS_BANK_RESET = 32'h0000_0000;
    localparam logic [4:0] ATS_SEL_RESET = 5'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int ATS_SEL_W = 5;
    localparam int ATS_FIELD_STRIDE = 8;
    localparam int ATS_NUM_CH = 11;
    localparam int ATS_NUM_CODES = 32;
    // Channel index of the first field of each bank
    localparam int ATS_BANK2_FIRST = 0;
    localparam int ATS_BANK3_FIRST = 3;
    localparam int ATS_BANK4_FIRST = 7;
    localparam int ATS_BANK2_FIELDS = 3;
    localparam int ATS_BANK_FIELDS = 4;

    // ------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ATS_HTRANS_NONSEQ = 2'h2;
    localparam logic ATS_HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sw_edge;
        logic sw_level;
        logic scan;
        logic ext_int0;
        logic gp_timer1;
        logic gp_timer3;
        logic gp_timer5;
        logic pri_special;
        logic sec_special;
        logic [11:0] pwm_trig;
        logic [3:0] oc_rise;
        logic charge_time_measurement_unit_trip;
        logic [3:0] pwm_climit;
    } ats_src_type;

    typedef struct packed {
        logic hsel;
        logic [ATS_ADDR_W-1:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } ats_ahb_req_type;

endpackage

// ==== sim/ats_src_model.sv ====
// Model of the on-chip event sources feeding the selector
`timescale 1ns/1ps
module ats_src_model
import ats_pkg::*;
(
    input wire logic [4:0] i_code, // Source to raise, by code
    input wire logic i_fire, // Raise it for this cycle
    output ats_pkg::ats_src_type o_src // Event lines
);
    logic [31:0] v;
    // Codes 0 and 31 reach no line at all
    always_comb
    begin
        v = 32'h0;
        v[i_code] = i_fire;
        o_src.sw_edge = v[1];
        o_src.sw_level = v[2];
        o_src.scan = v[3];
        o_src.ext_int0 = v[4];
        o_src.gp_timer1 = v[5];
        o_src.gp_timer3 = v[6];
        o_src.gp_timer5 = v[7];
        o_src.pri_special = v[8];
        o_src.sec_special = v[9];
        o_src.pwm_trig = {v[30:28], v[23:21], v[15:10]};
        o_src.oc_rise = v[19:16];
        o_src.charge_time_measurement_unit_trip = v[20];
        o_src.pwm_climit = v[27:24];
    end
endmodule

// ==== sim/ats_trigger_select_properties.sv ====
// Port checks of the trigger selector
`timescale 1ns/1ps
module ats_trigger_select_properties
import ats_pkg::*;
(
    input wire logic I_MCLK, // Clock
    input wire logic I_SYS_RST, // Reset
    input wire ats_pkg::ats_ahb_req_type I_AHB, // Address phase
    input wire logic [31:0] I_HWDATA, // Write data
    input wire logic [31:0] O_HRDATA, // Read data
    input wire logic O_HREADYOUT, // Ready
    input wire logic O_HRESP, // Response
    input wire ats_pkg::ats_src_type I_TRIG_SRC, // Events
    input wire logic [ATS_NUM_CH-1:0] O_CONV_REQ, // Requests
    input wire logic [ATS_NUM_CH-1:0] O_TRIG_LEVEL // Levels
);
    default clocking @(posedge I_MCLK);
    endclocking
    default disable iff (I_SYS_RST);
    sequence rd_any;
        I_AHB.hsel && I_AHB.hready && I_AHB.htrans[1] && !I_AHB.hwrite;
    endsequence
    chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus stalled or not OKAY");
    chk_req_single: assert property (|O_CONV_REQ |=>
        (O_CONV_REQ & $past(O_CONV_REQ)) == '0) else $error("long request");
    chk_req_level: assert property ((O_CONV_REQ & ~O_TRIG_LEVEL) == '0)
        else $error("request without level");
    chk_req_edge: assert property (|O_CONV_REQ |->
        (O_CONV_REQ & $past(O_TRIG_LEVEL)) == '0) else $error("no edge");
    chk_src_quiet: assert property (I_TRIG_SRC == '0 |=>
        O_TRIG_LEVEL == '0 && O_CONV_REQ == '0) else $error("phantom event");
    chk_rd_reserved: assert property (rd_any |=>
        (O_HRDATA & 32'hE0E0_E0E0) == 32'h0) else $error("reserved bits set");
    chk_bank2_top: assert property (rd_any ##0 I_AHB.haddr == ATS_OFS_BANK2
        |=> O_HRDATA[31:24] == 8'h00) else $error("bank2 top set");
    chk_status_rd: assert property (rd_any ##0 I_AHB.haddr == ATS_OFS_STATUS
        |=> O_HRDATA == {21'h0, $past(O_TRIG_LEVEL)})
        else $error("status mismatch");
endmodule

bind ats_trigger_select ats_trigger_select_properties u_chk (
    .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_AHB(I_AHB),
    .I_HWDATA(I_HWDATA), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .I_TRIG_SRC(I_TRIG_SRC), .O_CONV_REQ(O_CONV_REQ),
    .O_TRIG_LEVEL(O_TRIG_LEVEL));

// ==== sim/tb_top.sv ====
// Self-checking bench of the trigger selector
`timescale 1ns/1ps
module tb_top;
    import ats_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ats_ahb_req_type ahb = '0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ats_src_type src;
    logic [ATS_NUM_CH-1:0] req;
    logic [ATS_NUM_CH-1:0] lvl;
    logic [4:0] code = 5'h00;
    logic fire = 1'b0;
    logic [31:0] seed = 32'hBB63865C;
    logic [4:0] sel [ATS_NUM_CH];
    int errors = 0;
    int n_tests = 0;

    always #4 clk = ~clk;

    ats_trigger_select #(.MOTOR_CONTROL(1'b1)) DUT (
        .I_MCLK(clk), .I_SYS_RST(rst), .I_AHB(ahb), .I_HWDATA(hwdata),
        .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
        .I_TRIG_SRC(src), .O_CONV_REQ(req), .O_TRIG_LEVEL(lvl));
    ats_src_model u_src (.i_code(code), .i_fire(fire), .o_src(src));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] addr_of(input int ch);
        return ch < 3 ? ATS_OFS_BANK2 : ch < 7 ? ATS_OFS_BANK3 : ATS_OFS_BANK4;
    endfunction
    function automatic int sh_of(input int ch);
        return 8 * (ch < 3 ? ch : ch < 7 ? ch - 3 : ch - 7);
    endfunction
    // Reserved code 31 and code 0 must never fire any channel
    function automatic logic [31:0] exp_req(input logic [4:0] c);
        exp_req = 32'h0;
        for (int i = 0; i < ATS_NUM_CH; i++)
            exp_req[i] = sel[i] == c && c != 5'h00 && c != 5'h1F;
    endfunction

    task automatic end_sim;
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            errors++;
            end_sim();
        end
    endtask
    // One single word transfer; called right after a rising edge
    task automatic bus(input logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r);
        ahb <= '{hsel: 1'b1, haddr: a, htrans: ATS_HTRANS_NONSEQ,
                 hwrite: w, hsize: 3'h2, hready: hreadyout};
        wait_rdy();
        // Idle keeps hready up, as the one slave never stalls the bus
        ahb <= '{hsel: 1'b0, haddr: 8'h00, htrans: 2'h0,
                 hwrite: 1'b0, hsize: 3'h0, hready: hreadyout};
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    initial
    begin
        logic [31:0] rd;
        logic [31:0] m;
        logic [7:0] a8;
        int ch;
        for (int i = 0; i < ATS_NUM_CH; i++)
            sel[i] = 5'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4)
        begin
            bus(1'b0, 8'(a), 32'h0, rd);
            cmp("reset", ATS_BANK_RESET, rd);
        end
        for (int k = 0; k < 12; k++)
        begin
            seed = k == 0 ? 32'hFFFFFFFF : lfsr(seed);
            a8 = 8'(4 * (k % 3));
            m = a8 == ATS_OFS_BANK2 ? 32'h001F1F1F : 32'h1F1F1F1F;
            bus(1'b1, a8, seed, rd);
            bus(1'b0, a8, 32'h0, rd);
            cmp("bank", seed & m, rd);
            bus(1'b1, a8, 32'h0, rd);
        end
        bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h10, 32'h0, rd);
        cmp("unmapped", 32'h0, rd);
        for (int c = 0; c < ATS_NUM_CODES; c++)
        begin
            seed = lfsr(seed);
            ch = int'(seed % ATS_NUM_CH);
            sel[ch] = 5'(c);
            bus(1'b0, addr_of(ch), 32'h0, rd);
            m = (rd & ~(32'h1F << sh_of(ch))) | (32'(c) << sh_of(ch));
            bus(1'b1, addr_of(ch), m, rd);
            code <= 5'(c);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            #1;
            cmp("req", exp_req(5'(c)), 32'(req));
            cmp("lvl", exp_req(5'(c)), 32'(lvl));
            @(posedge clk);
        end
        // A second reset mid-run must clear the bank 3 fields again
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, ATS_OFS_BANK3, 32'h0, rd);
        cmp("rereset", ATS_BANK_RESET, rd);
        end_sim();
    end
endmodule
